/* uart_mcs_cfg.svh */
// Offsets, field positions and reset values of the modem control block
//
// Overview of operation
// [R1] Status bit 4 shows the inverse of the clear-to-send input.
// [R2] Status bit 0 sets when clear-to-send changed since last status read.
// [R3] Status bit 5 shows the inverse of the data-set-ready input.
// [R4] Status bit 1 sets when data-set-ready changed since last status read.
// [R5] Status bit 6 shows the inverse of the ring-indicator input.
// [R6] Status bit 2 sets when ring-indicator goes low to high after the read.
// [R7] Status bit 7 shows the inverse of the carrier-detect input.
// [R8] Status bit 3 sets when carrier-detect changed since last status read.
// [R9] With enable bit 3 set, any modem input change raises the interrupt.
// [R10] Clear-to-send never gates or alters the serial transmit path.
// [R11] Terminal-ready pin is driven low when control bit 0 is one.
// [R12] Request-to-send pin is driven low when control bit 1 is one.
// [R13] Reset returns request-to-send to its inactive high level.
// [R14] Loop mode holds request-to-send inactive whatever control bits say.
// [R15] Reset and loop mode keep terminal-ready inactive.
// [R16] Each shared pin used as general I/O has its own direction bit.
// [R17] Reading status clears change flags 0 to 3 and the pending interrupt.
`ifndef UART_MCS_CFG_SVH
`define UART_MCS_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_MCR       8'h00
`define OFS_MSR       8'h04
`define OFS_IER       8'h08
`define OFS_IST       8'h0c
`define OFS_IMSK      8'h10
`define OFS_GFN       8'h14
`define OFS_GDIR      8'h18
`define OFS_GOUT      8'h1c
`define OFS_GIN       8'h20

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MCR_DTR       0
`define MCR_RTS       1
`define MCR_OUT1      2
`define MCR_OUT2      3
`define MCR_LOOP      4
`define IER_MODEM     3
`define IST_MODEM     0
`define LN_CTS        0
`define LN_DSR        1
`define LN_RI         2
`define LN_DCD        3
`define MSR_CTS       4
`define MSR_DSR       5
`define MSR_RI        6
`define MSR_DCD       7
`define PIN_CTS       7
`define PIN_DSR       6
`define PIN_DTR       5
`define PIN_SIN       4
`define PIN_RI        3
`define PIN_RTS       2
`define PIN_SOUT      1
`define PIN_DCD       0
`define UART_OUT_MASK 8'h26

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_MCR       5'h00
`define RST_IER       4'h0
`define RST_BYTE      8'h00
`define RST_NIB       4'h0
`define RST_LVL       4'h0
`define RST_PINS_OUT  8'hff
`define RST_PINS_OE   8'h26

`endif

/* uart_mcs_pkg.sv */
// Types shared by the modem control block
package uart_mcs_pkg;
  typedef enum logic [1:0] {
    PH_IDLE   = 2'b01,
    PH_ANSWER = 2'b10
  } apb_phase_t;
endpackage

/* uart_modem_control_status.sv */
// Modem handshake control, modem status and shared pin I/O behind APB
`timescale 1ns/1ps
`include "uart_mcs_cfg.svh"

module uart_modem_control_status
  import uart_mcs_pkg::*;
#(
  parameter int PINS = 8
) (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic [PINS-1:0] pin_in,
  output logic      [PINS-1:0] pin_out,
  output logic      [PINS-1:0] pin_oe,
  input  wire logic            serial_tx_line,
  output logic                 serial_rx_line,
  output logic                 irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  apb_phase_t      phase;
  logic [4:0]      modem_line_control_reg;
  logic [3:0]      ier;
  logic [3:0]      lvl;
  logic [3:0]      flags;
  logic [3:0]      snap;
  logic            ist;
  logic            imsk;
  logic [PINS-1:0] gfn;
  logic [PINS-1:0] gdir;
  logic [PINS-1:0] gout;

  // Set wins over clear so an event in the clearing cycle survives
  function automatic logic [3:0] sticky_upd(input logic [3:0] cur,
                                            input logic [3:0] set,
                                            input logic [3:0] clr);
    sticky_upd = set | (cur & ~clr);
  endfunction

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire        setup_cyc = psel & ~penable & (phase == PH_IDLE);
  wire        xfer_done = psel & penable & (phase == PH_ANSWER);
  wire        wr_done   = xfer_done & pwrite;
  wire        rd_done   = xfer_done & ~pwrite;
  wire        hit_mcr   = (paddr == `OFS_MCR);
  wire        hit_msr   = (paddr == `OFS_MSR);
  wire        hit_ier   = (paddr == `OFS_IER);
  wire        hit_ist   = (paddr == `OFS_IST);
  wire        hit_imsk  = (paddr == `OFS_IMSK);
  wire        hit_gfn   = (paddr == `OFS_GFN);
  wire        hit_gdir  = (paddr == `OFS_GDIR);
  wire        hit_gout  = (paddr == `OFS_GOUT);
  wire        hit_gin   = (paddr == `OFS_GIN);
  wire        mapped    = hit_mcr | hit_msr | hit_ier | hit_ist | hit_imsk |
                          hit_gfn | hit_gdir | hit_gout | hit_gin;
  wire        loop      = modem_line_control_reg[`MCR_LOOP];
  wire [31:0] rd_word   =
    hit_mcr  ? {27'h0, modem_line_control_reg} :
    hit_msr  ? {24'h0, lvl, flags} :
    hit_ier  ? {28'h0, ier} :
    hit_ist  ? {31'h0, ist} :
    hit_imsk ? {31'h0, imsk} :
    hit_gfn  ? {{(32-PINS){1'b0}}, gfn} :
    hit_gdir ? {{(32-PINS){1'b0}}, gdir} :
    hit_gout ? {{(32-PINS){1'b0}}, gout} :
    hit_gin  ? {{(32-PINS){1'b0}}, pin_in} : 32'h0;

  // ----------------------------------------------------------------
  // Modem inputs
  // ----------------------------------------------------------------
  // Loop mode feeds the control bits back; a pin given to general I/O
  // reads as an inactive modem line
  wire [3:0] line_n;
  assign line_n[`LN_CTS] = loop ? ~modem_line_control_reg[`MCR_RTS]
                                : (gfn[`PIN_CTS] | pin_in[`PIN_CTS]);
  assign line_n[`LN_DSR] = loop ? ~modem_line_control_reg[`MCR_DTR]
                                : (gfn[`PIN_DSR] | pin_in[`PIN_DSR]);
  assign line_n[`LN_RI]  = loop ? ~modem_line_control_reg[`MCR_OUT1]
                                : (gfn[`PIN_RI] | pin_in[`PIN_RI]);
  assign line_n[`LN_DCD] = loop ? ~modem_line_control_reg[`MCR_OUT2]
                                : (gfn[`PIN_DCD] | pin_in[`PIN_DCD]);

  wire [3:0] next_lvl = ~line_n; // [R1] [R3] [R5] [R7]
  wire [3:0] chg      = next_lvl ^ lvl;
  wire [3:0] flag_set;
  assign flag_set[`LN_CTS] = chg[`LN_CTS]; // [R2]
  assign flag_set[`LN_DSR] = chg[`LN_DSR]; // [R4]
  assign flag_set[`LN_RI]  = lvl[`LN_RI] & ~next_lvl[`LN_RI]; // [R6]
  assign flag_set[`LN_DCD] = chg[`LN_DCD]; // [R8]

  // Only flags already shown in the read data are cleared, so a change
  // arriving between capture and completion is not lost
  wire       msr_rd     = rd_done & hit_msr;
  wire [3:0] msr_clr    = {4{msr_rd}} & snap; // [R17]
  wire [3:0] next_flags = sticky_upd(flags, flag_set, msr_clr);

  // ----------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------
  wire ist_set  = ier[`IER_MODEM] & (|chg); // [R9]
  wire ist_w1c  = wr_done & hit_ist & pwdata[`IST_MODEM];
  wire ist_rdc  = msr_rd & ~(|(flags & ~snap)); // [R17]
  wire [3:0] ist_vec  = sticky_upd({3'h0, ist}, {3'h0, ist_set},
                                   {3'h0, ist_w1c | ist_rdc});
  wire next_ist = ist_vec[0];
  wire next_irq = next_ist & imsk;

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  wire [PINS-1:0] u_out;
  assign u_out[`PIN_CTS]  = 1'b1;
  assign u_out[`PIN_DSR]  = 1'b1;
  assign u_out[`PIN_DTR]  = loop |
                            ~modem_line_control_reg[`MCR_DTR]; // [R11] [R15]
  assign u_out[`PIN_SIN]  = 1'b1;
  assign u_out[`PIN_RI]   = 1'b1;
  assign u_out[`PIN_RTS]  = loop |
                            ~modem_line_control_reg[`MCR_RTS]; // [R12] [R14]
  // Transmit data passes untouched by clear-to-send; idles high in loop
  assign u_out[`PIN_SOUT] = loop | serial_tx_line; // [R10]
  assign u_out[`PIN_DCD]  = 1'b1;

  wire [PINS-1:0] next_pin_out = (gfn & gout) | (~gfn & u_out);
  wire [PINS-1:0] next_pin_oe  = (gfn & gdir) |
                                 (~gfn & `UART_OUT_MASK); // [R16]
  wire            next_rx      = loop ? serial_tx_line
                                      : (gfn[`PIN_SIN] | pin_in[`PIN_SIN]);

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // No wait state: data is captured in setup, the answer lasts one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase   <= PH_IDLE;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
      snap    <= `RST_NIB;
    end else if (setup_cyc) begin
      phase   <= PH_ANSWER;
      pready  <= 1'b1;
      pslverr <= ~mapped;
      prdata  <= pwrite ? 32'h0 : rd_word;
      snap    <= (hit_msr & ~pwrite) ? flags : `RST_NIB;
    end else if (xfer_done) begin
      phase   <= PH_IDLE;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modem_line_control_reg <= `RST_MCR; // [R13] [R15]
      ier  <= `RST_IER;
      imsk <= 1'b0;
      gfn  <= `RST_BYTE;
      gdir <= `RST_BYTE;
      gout <= `RST_BYTE;
    end else if (wr_done) begin
      if (hit_mcr)  modem_line_control_reg <= pwdata[4:0];
      if (hit_ier)  ier  <= pwdata[3:0];
      if (hit_imsk) imsk <= pwdata[`IST_MODEM];
      if (hit_gfn)  gfn  <= pwdata[PINS-1:0];
      if (hit_gdir) gdir <= pwdata[PINS-1:0]; // [R16]
      if (hit_gout) gout <= pwdata[PINS-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Status, interrupt and pin flops
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl   <= `RST_LVL;
      flags <= `RST_NIB;
      ist   <= 1'b0;
      irq   <= 1'b0;
    end else begin
      lvl   <= next_lvl;
      flags <= next_flags;
      ist   <= next_ist;
      irq   <= next_irq;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out        <= `RST_PINS_OUT; // [R13] [R15]
      pin_oe         <= `RST_PINS_OE;
      serial_rx_line <= 1'b1;
    end else begin
      pin_out        <= next_pin_out;
      pin_oe         <= next_pin_oe;
      serial_rx_line <= next_rx;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_msr_setup;
    psel && !penable && !pwrite && hit_msr && phase == PH_IDLE;
  endsequence

  sequence s_msr_done;
    psel && penable && !pwrite && hit_msr && phase == PH_ANSWER;
  endsequence

  cts_level_a: assert property ( // [R1]
    lvl[`LN_CTS] == ~$past(line_n[`LN_CTS]))
    else $error("cts status level not inverse of input");

  dsr_level_a: assert property ( // [R3]
    !loop && !gfn[`PIN_DSR] && $stable(gfn) && $stable(loop)
    |=> lvl[`LN_DSR] == ~$past(pin_in[`PIN_DSR]))
    else $error("dsr status level not inverse of pin");

  ri_level_a: assert property ( // [R5]
    lvl[`LN_RI] == ~$past(line_n[`LN_RI]))
    else $error("ri status level not inverse of input");

  dcd_level_a: assert property ( // [R7]
    lvl[`LN_DCD] == ~$past(line_n[`LN_DCD]))
    else $error("dcd status level not inverse of input");

  cts_change_a: assert property ( // [R2]
    $changed(lvl[`LN_CTS]) |-> flags[`LN_CTS])
    else $error("cts change not flagged");

  dsr_change_a: assert property ( // [R4]
    $changed(lvl[`LN_DSR]) |-> flags[`LN_DSR])
    else $error("dsr change not flagged");

  ri_edge_a: assert property ( // [R6]
    $fell(lvl[`LN_RI]) |-> flags[`LN_RI])
    else $error("ri trailing edge not flagged");

  ri_noedge_a: assert property ( // [R6]
    !$fell(lvl[`LN_RI]) && !$past(flags[`LN_RI]) |-> !flags[`LN_RI])
    else $error("ri flag set without trailing edge");

  dcd_change_a: assert property ( // [R8]
    $changed(lvl[`LN_DCD]) |-> flags[`LN_DCD])
    else $error("dcd change not flagged");

  modem_irq_a: assert property ( // [R9]
    $changed(lvl) && $past(ier[`IER_MODEM]) && $past(imsk) |-> irq)
    else $error("modem change did not raise interrupt");

  tx_pass_a: assert property ( // [R10]
    !loop && !gfn[`PIN_SOUT]
    |=> pin_out[`PIN_SOUT] == $past(serial_tx_line))
    else $error("transmit pin altered");

  dtr_drive_a: assert property ( // [R11]
    !loop && !gfn[`PIN_DTR]
    |=> pin_out[`PIN_DTR] == ~$past(modem_line_control_reg[`MCR_DTR]))
    else $error("dtr pin not following control bit");

  rts_drive_a: assert property ( // [R12]
    !loop && !gfn[`PIN_RTS]
    |=> pin_out[`PIN_RTS] == ~$past(modem_line_control_reg[`MCR_RTS]))
    else $error("rts pin not following control bit");

  loop_quiet_a: assert property ( // [R14]
    loop && !gfn[`PIN_RTS] && !gfn[`PIN_DTR]
    |=> pin_out[`PIN_RTS] && pin_out[`PIN_DTR])
    else $error("handshake output active in loop mode");

  gpio_dir_a: assert property ( // [R16]
    gfn[`PIN_CTS] |=> pin_oe[`PIN_CTS] == $past(gdir[`PIN_CTS]))
    else $error("gpio direction not applied");

  msr_clear_a: assert property ( // [R17]
    s_msr_setup ##1 (s_msr_done and (!(|flag_set) && !ist_set))
    |=> (flags & $past(snap)) == 4'h0 && !ist)
    else $error("status read did not clear flags");

  bus_answer_a: assert property (
    psel && !penable && phase == PH_IDLE |=> pready [*1] ##1 !pready)
    else $error("apb answer not one cycle");

endmodule

/* modem_far_end.sv */
// Far-side modem model: drives modem lines and receive data onto the pins
`timescale 1ns/1ps

module modem_far_end (
  input  wire logic [3:0] lines_n,
  input  wire logic       rx_level,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  output logic      [7:0] pin_in
);
  // ----------------------------------------------------------------
  // Pin levels
  // ----------------------------------------------------------------
  // lines_n order: 0 cts, 1 dsr, 2 ri, 3 dcd, all active low
  logic [7:0] far;

  // Pins the modem never drives are pulled up, so they read idle high
  assign far = {lines_n[0], lines_n[1], 1'b1, rx_level,
                lines_n[2], 1'b1, 1'b1, lines_n[3]};

  // A pin driven by the device shows the device level on the wire
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & far);
endmodule

/* tb.sv */
// Self-checking testbench for the modem control and status block
`timescale 1ns/1ps
`include "uart_mcs_cfg.svh"

`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb;
  import uart_mcs_pkg::*;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  pin_in;
  logic [7:0]  pin_out;
  logic [7:0]  pin_oe;
  logic        serial_tx_line;
  logic        serial_rx_line;
  logic        irq;
  logic [3:0]  lines_n;
  logic        rx_level;
  logic        last_err;
  logic [31:0] rnd;
  logic [31:0] q;
  logic [3:0]  prev;
  logic [3:0]  nxt;
  logic [7:0]  g;
  logic [7:0]  o;
  logic [1:0]  v;
  logic [7:0]  far;
  int          err_total;
  int          checked;

  uart_modem_control_status i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .serial_tx_line(serial_tx_line),
    .serial_rx_line(serial_rx_line), .irq(irq)
  );

  modem_far_end i_modem (
    .lines_n(lines_n), .rx_level(rx_level), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_in(pin_in)
  );

  initial pclk = 1'b0;
  always #20 pclk = ~pclk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic end_of_test;
    $display("checks=%0d errors=%0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // One APB transfer; an idle cycle follows so no signal is set twice
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      err_total++;
      end_of_test();
    end else begin
      @(posedge pclk);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    `CHK(r, e)
  endtask

  // Levels are inverted; ring flag only on a low-to-high of the pin
  function automatic logic [31:0] exp_msr(logic [3:0] o_n, logic [3:0] n_n);
    logic [3:0] f;
    f = o_n ^ n_n;
    f[2] = ~o_n[2] & n_n[2];
    return {24'h0, ~n_n, f};
  endfunction

  task automatic settle;
    repeat (2) @(posedge pclk);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; lines_n = 4'hf; rx_level = 1'b1;
    serial_tx_line = 1'b1; err_total = 0; checked = 0;
    rnd = $urandom(32'h1138);
    repeat (3) @(posedge pclk);
    `CHK(pin_out, 8'hff)
    `CHK(pin_oe, 8'h26)
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`OFS_MCR, 32'h0);
    rd(`OFS_MSR, 32'h0);
    rd(8'h40, 32'h0);
    `CHK(last_err, 1'b1)
    for (int i = 0; i < 4; i++) begin
      v = i[1:0];
      wr(`OFS_MCR, {30'h0, v});
      settle();
      `CHK(pin_out[`PIN_DTR], ~v[0])
      `CHK(pin_out[`PIN_RTS], ~v[1])
    end
    // Loop mode: handshake pins forced idle, all four control bits fed back
    wr(`OFS_MCR, 32'h1f);
    serial_tx_line <= 1'b0;
    settle();
    `CHK(pin_out[`PIN_DTR], 1'b1)
    `CHK(pin_out[`PIN_RTS], 1'b1)
    `CHK(serial_rx_line, 1'b0)
    rd(`OFS_MSR, 32'hfb);
    wr(`OFS_MCR, 32'h0);
    serial_tx_line <= 1'b1;
    settle();
    rd(`OFS_MSR, 32'h0f);
    // Modem line changes: single toggles first, then random patterns
    prev = 4'hf;
    for (int k = 0; k < 14; k++) begin
      rnd = $urandom;
      nxt = (k < 4) ? prev ^ (4'h1 << k) : rnd[3:0];
      lines_n <= nxt;
      settle();
      rd(`OFS_MSR, exp_msr(prev, nxt));
      rd(`OFS_MSR, {24'h0, ~nxt, 4'h0});
      prev = nxt;
    end
    // Transmit path ignores the clear-to-send line
    for (int k = 0; k < 6; k++) begin
      rnd = $urandom;
      serial_tx_line <= rnd[0];
      rx_level <= rnd[1];
      lines_n[0] <= rnd[2];
      settle();
      `CHK(pin_out[`PIN_SOUT], serial_tx_line)
      `CHK(serial_rx_line, rx_level)
    end
    apb(1'b0, `OFS_MSR, 32'h0, q);
    `CHK(q[7:4], ~lines_n)
    prev = lines_n;
    // Interrupt: raise, clear by status read, clear by W1C, then masked
    wr(`OFS_IER, 32'h8);
    wr(`OFS_IMSK, 32'h1);
    prev[0] = ~prev[0];
    lines_n <= prev;
    settle();
    `CHK(irq, 1'b1)
    rd(`OFS_IST, 32'h1);
    apb(1'b0, `OFS_MSR, 32'h0, q);
    `CHK(q, {24'h0, ~prev, 4'h1})
    @(posedge pclk);
    `CHK(irq, 1'b0)
    prev[3] = ~prev[3];
    lines_n <= prev;
    settle();
    `CHK(irq, 1'b1)
    wr(`OFS_IST, 32'h1);
    @(posedge pclk);
    `CHK(irq, 1'b0)
    wr(`OFS_IMSK, 32'h0);
    prev[1] = ~prev[1];
    lines_n <= prev;
    settle();
    `CHK(irq, 1'b0)
    rd(`OFS_IST, 32'h1);
    // General I/O: per-pin direction
    rnd = $urandom;
    g = rnd[7:0];
    o = rnd[15:8];
    wr(`OFS_GFN, 32'hff);
    wr(`OFS_GDIR, {24'h0, g});
    wr(`OFS_GOUT, {24'h0, o});
    settle();
    `CHK(pin_oe, g)
    `CHK(pin_out & g, o & g)
    far = {lines_n[0], lines_n[1], 1'b1, rx_level,
           lines_n[2], 1'b1, 1'b1, lines_n[3]};
    rd(`OFS_GIN, {24'h0, (g & o) | (~g & far)});
    // Reset in mid-run with both handshake pins asserted
    wr(`OFS_GFN, 32'h0);
    wr(`OFS_MCR, 32'h3);
    settle();
    `CHK(pin_out[`PIN_RTS], 1'b0)
    `CHK(pin_out[`PIN_DTR], 1'b0)
    presetn <= 1'b0;
    @(posedge pclk);
    `CHK(pin_out[`PIN_RTS], 1'b1)
    `CHK(pin_out[`PIN_DTR], 1'b1)
    end_of_test();
  end
endmodule
